// [design/dither_marker_link_ctrl.sv]
// control registers for dither, sample marker, link enable and link mode
//
// Operation
// R1: dither control bit 0 enables dither
// R2: dither bit 1 selects small or large
// R3: dither bit 2 steers rounding error
// R4: software writes reserved bits at reset value
// R5: marker enable puts marker in sample lsb
// R6: marker latency matches converter sample latency
// R7: marker fills lowest bit of link field
// R8: lane alignment data reports zero control bits
// R9: software enables marker receiver with insertion
// R10: link enable bit 0, resets enabled
// R11: software clears link enable before reconfiguring
// R12: link disabled: reset, serializer down, clocks gated
// R13: link disabled holds multiframe clock counter reset
// R14: calibration enable set before link enable
// R15: link enable cleared before calibration enable
// R16: six-bit field selects link output mode
// R17: mode changed only with link, calibration off
// R18: new mode applied on next link enable
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

`include "dither_marker_regs.svh"

module dither_marker_link_ctrl #(
  parameter int CONV_W     = 12,
  parameter int LINK_W     = 16,
  parameter int MARKER_LAT = `MARKER_PIPE_DEPTH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [11:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // converter sample path
  input  wire logic [CONV_W-1:0] conv_sample,
  input  wire logic              conv_valid,
  input  wire logic              marker_pin,
  output logic      [LINK_W-1:0] link_sample,
  output logic                   link_valid,
  // converter dither controls
  output logic                   dither_enable,
  output logic                   dither_amplitude_select,
  output logic                   rounding_error_steer,
  // marker receiver and calibration
  output logic                   marker_receiver_enable,
  output logic                   calibration_enable,
  // link subsystem controls
  output logic                   link_reset_b,
  output logic                   serializer_power_up,
  output logic                   link_clock_gate_en,
  output logic                   multiframe_clock_counter_reset_b,
  output logic                   link_init_start,
  output logic      [5:0]        link_mode_active,
  output logic      [3:0]        ila_control_bits
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]                     dither_reg;
    logic [7:0]                     marker_reg;
    logic [7:0]                     recv_reg;
    logic [7:0]                     cal_reg;
    logic [7:0]                     link_en_reg;
    logic [7:0]                     mode_reg;
    logic [5:0]                     mode_active;
    dither_marker_pkg::link_state_t lstate;
    logic [7:0]                     rdata;
    logic [1:0]                     marker_sync;
    logic [CONV_W-1:0]              sample_hold;
    logic                           sample_valid;
    logic [LINK_W-1:0]              link_sample;
    logic                           link_valid;
    logic                           link_reset_b;
    logic                           ser_pwr;
    logic                           clk_gate;
    logic                           mfc_reset_b;
    logic                           init_start;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic        marker_dly;
  logic        sample_dly_v;

  // decode one address against the register port
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************************************
  // marker alignment
  // ****************************************************************
  // R6: latency match
  // the pin synchroniser costs one stage more than the sample hold, so one less here
  marker_delay_line #(
    .DEPTH (MARKER_LAT - 1)
  ) u_marker_delay (
    .clk        (clk),
    .rst_b      (rst_b),
    .marker_in  (s_q.marker_sync[1]),
    .marker_out (marker_dly)
  );

  // samples see the same depth so markers stay beside them
  logic [CONV_W-1:0] samp_pipe [MARKER_LAT];
  logic [MARKER_LAT-1:0] samp_vpipe;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_vpipe <= '0;
      for (int i = 0; i < MARKER_LAT; i++) begin
        samp_pipe[i] <= '0;
      end
    end else begin
      samp_vpipe <= {samp_vpipe[MARKER_LAT-2:0], s_q.sample_valid};
      samp_pipe[0] <= s_q.sample_hold;
      for (int i = 1; i < MARKER_LAT; i++) begin
        samp_pipe[i] <= samp_pipe[i-1];
      end
    end
  end
  assign sample_dly_v = samp_vpipe[MARKER_LAT-1];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.init_start = 1'b0;

    // pin synchroniser: second stage only is read downstream
    s_d.marker_sync = {s_q.marker_sync[0], marker_pin};
    s_d.sample_hold  = conv_sample;
    s_d.sample_valid = conv_valid;

    // register writes store every bit; reserved bits are kept as written
    // R4: reserved bits stored
    if (reg_wr) begin
      if (hit(reg_addr, `OFS_CONVERTER_DITHER_CTRL)) begin
        s_d.dither_reg = reg_wdata;
      end
      if (hit(reg_addr, `OFS_SAMPLE_MARKER_CTRL)) begin
        s_d.marker_reg = reg_wdata;
      end
      if (hit(reg_addr, `OFS_MARKER_RECEIVER_CTRL)) begin
        s_d.recv_reg = reg_wdata;
      end
      if (hit(reg_addr, `OFS_CALIBRATION_CTRL)) begin
        s_d.cal_reg = reg_wdata;
      end
      // R10: link enable store
      if (hit(reg_addr, `OFS_SERIAL_LINK_ENABLE)) begin
        s_d.link_en_reg = reg_wdata;
      end
      // R16: mode field store
      if (hit(reg_addr, `OFS_LINK_OUTPUT_MODE)) begin
        s_d.mode_reg = reg_wdata;
      end
    end

    // read data one cycle after the strobe, zero for unmapped addresses
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_CONVERTER_DITHER_CTRL: s_d.rdata = s_q.dither_reg;
        `OFS_SAMPLE_MARKER_CTRL:    s_d.rdata = s_q.marker_reg;
        `OFS_MARKER_RECEIVER_CTRL:  s_d.rdata = s_q.recv_reg;
        `OFS_CALIBRATION_CTRL:      s_d.rdata = s_q.cal_reg;
        `OFS_SERIAL_LINK_ENABLE:    s_d.rdata = s_q.link_en_reg;
        `OFS_LINK_OUTPUT_MODE:      s_d.rdata = s_q.mode_reg;
        `OFS_LINK_STATUS:           s_d.rdata = {2'b00, s_q.mode_active};
        default:                    s_d.rdata = 8'h00;
      endcase
    end

    // link power sequence
    unique case (s_q.lstate)
      dither_marker_pkg::LINK_OFF: begin
        if (s_q.link_en_reg[`BIT_LINK_SUBSYSTEM_ENABLE]) begin
          // R18: mode latched on enable
          s_d.mode_active = s_q.mode_reg[`MSB_LINK_MODE_SELECT:0];
          s_d.lstate      = dither_marker_pkg::LINK_START;
        end
      end
      dither_marker_pkg::LINK_START: begin
        // R18: restart initialization
        s_d.init_start = 1'b1;
        s_d.lstate     = dither_marker_pkg::LINK_RUN;
      end
      dither_marker_pkg::LINK_RUN: begin
        if (!s_q.link_en_reg[`BIT_LINK_SUBSYSTEM_ENABLE]) begin
          s_d.lstate = dither_marker_pkg::LINK_OFF;
        end
      end
      // unused code: fall back to the safe powered-down state
      default: begin
        s_d.lstate = dither_marker_pkg::LINK_OFF;
      end
    endcase
    if (!s_q.link_en_reg[`BIT_LINK_SUBSYSTEM_ENABLE]) begin
      s_d.lstate = dither_marker_pkg::LINK_OFF;
    end

    // R12: reset, power down, gate
    s_d.link_reset_b = (s_d.lstate != dither_marker_pkg::LINK_OFF);
    s_d.ser_pwr      = (s_d.lstate != dither_marker_pkg::LINK_OFF);
    s_d.clk_gate     = (s_d.lstate != dither_marker_pkg::LINK_OFF);
    // R13: counter held in reset
    s_d.mfc_reset_b  = (s_d.lstate != dither_marker_pkg::LINK_OFF);

    // sample formatting: converter bits sit at the top of the link field
    s_d.link_valid  = sample_dly_v && s_q.link_reset_b;
    s_d.link_sample = '0;
    s_d.link_sample[LINK_W-1 -: CONV_W] = samp_pipe[MARKER_LAT-1];
    // R5: marker into lsb
    // R7: lowest link bit
    if (s_q.marker_reg[`BIT_MARKER_INSERT_ENABLE]) begin
      s_d.link_sample[0] = marker_dly;
    end
    if (!s_q.link_reset_b) begin
      s_d.link_sample = '0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q             <= '0;
      s_q.dither_reg  <= `RST_CONVERTER_DITHER_CTRL;
      s_q.marker_reg  <= `RST_SAMPLE_MARKER_CTRL;
      s_q.recv_reg    <= `RST_MARKER_RECEIVER_CTRL;
      s_q.cal_reg     <= `RST_CALIBRATION_CTRL;
      // R10: resets enabled
      s_q.link_en_reg <= `RST_SERIAL_LINK_ENABLE;
      s_q.mode_reg    <= `RST_LINK_OUTPUT_MODE;
      s_q.mode_active <= 6'h00;
      s_q.lstate      <= dither_marker_pkg::LINK_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs, all from flip-flops except ila_control_bits, tied to constant zero
  // ****************************************************************
  // R1: dither enable
  assign dither_enable           = s_q.dither_reg[`BIT_DITHER_ENABLE];
  // R2: amplitude select
  assign dither_amplitude_select = s_q.dither_reg[`BIT_DITHER_AMPLITUDE];
  // R3: error steering
  assign rounding_error_steer    = s_q.dither_reg[`BIT_ROUNDING_ERROR_STEER];
  assign marker_receiver_enable  = s_q.recv_reg[`BIT_MARKER_RECEIVER_ENABLE];
  assign calibration_enable      = s_q.cal_reg[`BIT_CALIBRATION_ENABLE];
  assign link_reset_b            = s_q.link_reset_b;
  assign serializer_power_up     = s_q.ser_pwr;
  assign link_clock_gate_en      = s_q.clk_gate;
  assign multiframe_clock_counter_reset_b = s_q.mfc_reset_b;
  assign link_init_start         = s_q.init_start;
  assign link_mode_active        = s_q.mode_active;
  assign reg_rdata               = s_q.rdata;
  assign link_sample             = s_q.link_sample;
  assign link_valid              = s_q.link_valid;
  // R8: never advertised
  assign ila_control_bits        = 4'h0;

endmodule // dither_marker_link_ctrl

// [design/marker_delay_line.sv]
// fixed delay line that keeps the marker level aligned with its samples
`timescale 1ns/1ps

module marker_delay_line #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // marker stream
  input  wire logic marker_in,
  output logic      marker_out
);

  typedef struct packed {
    logic [DEPTH-1:0] pipe;
  } delay_state_t;

  delay_state_t s_q;
  delay_state_t s_d;

  // shift one stage per clock, matching the sample path depth
  always_comb begin
    s_d      = s_q;
    s_d.pipe = {s_q.pipe[DEPTH-2:0], marker_in};
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign marker_out = s_q.pipe[DEPTH-1];

endmodule // marker_delay_line

// [dv/dither_marker_link_ctrl_chk.sv]
// port assertions of the link control bank
`timescale 1ns/1ps

module dither_marker_link_ctrl_chk #(
  parameter int CONV_W     = 12,
  parameter int LINK_W     = 16,
  parameter int MARKER_LAT = 4
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst_b,
  // register port
  input wire logic [11:0]       reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  // sample path
  input wire logic [CONV_W-1:0] conv_sample,
  input wire logic              conv_valid,
  input wire logic              marker_pin,
  input wire logic [LINK_W-1:0] link_sample,
  input wire logic              link_valid,
  // controls
  input wire logic              dither_enable,
  input wire logic              dither_amplitude_select,
  input wire logic              rounding_error_steer,
  input wire logic              marker_receiver_enable,
  input wire logic              calibration_enable,
  input wire logic              link_reset_b,
  input wire logic              serializer_power_up,
  input wire logic              link_clock_gate_en,
  input wire logic              multiframe_clock_counter_reset_b,
  input wire logic              link_init_start,
  input wire logic [5:0]        link_mode_active,
  input wire logic [3:0]        ila_control_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // link shutdown steps
  // ****************************************************************
  // a disabling write not followed next cycle by any other write to the enable register
  sequence link_off_wr;
    reg_wr && reg_addr == 12'h200 && !reg_wdata[0] ##1 !(reg_wr && reg_addr == 12'h200);
  endsequence
  sequence link_down;
    !link_reset_b && !serializer_power_up && !link_clock_gate_en;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  dith_en_a: assert property (reg_wr && reg_addr == 12'h09D |=> dither_enable == $past(reg_wdata[0]))
    else $error("dither enable not taken from bit 0");
  dith_amp_a: assert property (reg_wr && reg_addr == 12'h09D |=> dither_amplitude_select == $past(reg_wdata[1]))
    else $error("dither amplitude not taken from bit 1");
  err_steer_a: assert property (reg_wr && reg_addr == 12'h09D |=> rounding_error_steer == $past(reg_wdata[2]))
    else $error("rounding steer not taken from bit 2");
  link_down_a: assert property (link_off_wr |=> link_down)
    else $error("link still powered after disable");
  mfc_hold_a: assert property (link_off_wr |=> !multiframe_clock_counter_reset_b)
    else $error("multiframe counter not held after disable");
  init_pulse_a: assert property ($rose(link_reset_b) |=> link_init_start ##1 !link_init_start)
    else $error("no single init pulse after enable");
  pulse_cause_a: assert property (link_init_start |-> $past(link_reset_b) && !$past(link_reset_b, 2))
    else $error("init pulse without fresh enable");
  mode_latch_a: assert property ($changed(link_mode_active) |-> $rose(link_reset_b))
    else $error("active mode changed outside enable rise");
  ila_zero_a: assert property (ila_control_bits == 4'h0)
    else $error("control bits advertised");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  off_quiet_a: assert property (!link_reset_b |=> link_sample == '0 && !link_valid)
    else $error("samples leave while link is off");
endmodule // dither_marker_link_ctrl_chk

bind dither_marker_link_ctrl dither_marker_link_ctrl_chk #(
  .CONV_W(CONV_W), .LINK_W(LINK_W), .MARKER_LAT(MARKER_LAT)
) chk_i (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_sample(conv_sample), .conv_valid(conv_valid),
  .marker_pin(marker_pin), .link_sample(link_sample), .link_valid(link_valid),
  .dither_enable(dither_enable), .dither_amplitude_select(dither_amplitude_select),
  .rounding_error_steer(rounding_error_steer), .marker_receiver_enable(marker_receiver_enable),
  .calibration_enable(calibration_enable), .link_reset_b(link_reset_b),
  .serializer_power_up(serializer_power_up), .link_clock_gate_en(link_clock_gate_en),
  .multiframe_clock_counter_reset_b(multiframe_clock_counter_reset_b),
  .link_init_start(link_init_start), .link_mode_active(link_mode_active),
  .ila_control_bits(ila_control_bits)
);

// [dv/dither_marker_link_ctrl_test.sv]
// register-level test of the link control bank
`timescale 1ns/1ps

module dither_marker_link_ctrl_test;
  // stimulus
  logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        conv_valid = 1'b0, marker_pin = 1'b0;
  logic [11:0] reg_addr = 12'h000, conv_sample = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  // observed outputs
  logic [7:0]  reg_rdata;
  logic [15:0] link_sample;
  logic [5:0]  link_mode_active;
  logic [3:0]  ila_control_bits;
  logic        link_valid, dither_enable, dither_amplitude_select, rounding_error_steer;
  logic        marker_receiver_enable, calibration_enable, link_reset_b, serializer_power_up;
  logic        link_clock_gate_en, multiframe_clock_counter_reset_b, link_init_start;
  // bookkeeping and reset table
  int          errors = 0;
  int          n_compared = 0;
  logic [11:0] ofs [4] = '{12'h09D, 12'h160, 12'h200, 12'h201};
  logic [7:0]  rstv [4] = '{8'h00, 8'h00, 8'h01, 8'h00};

  always #10 clk = ~clk;

  dither_marker_link_ctrl DUT (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_sample(conv_sample), .conv_valid(conv_valid),
    .marker_pin(marker_pin), .link_sample(link_sample), .link_valid(link_valid),
    .dither_enable(dither_enable), .dither_amplitude_select(dither_amplitude_select),
    .rounding_error_steer(rounding_error_steer), .marker_receiver_enable(marker_receiver_enable),
    .calibration_enable(calibration_enable), .link_reset_b(link_reset_b),
    .serializer_power_up(serializer_power_up), .link_clock_gate_en(link_clock_gate_en),
    .multiframe_clock_counter_reset_b(multiframe_clock_counter_reset_b),
    .link_init_start(link_init_start), .link_mode_active(link_mode_active),
    .ila_control_bits(ila_control_bits)
  );

  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write, returns once the update has landed
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  // long settle so both sample and marker pipes are full
  task automatic mk(input logic m, input logic e);
    @(posedge clk);
    marker_pin <= m;
    repeat (10) @(posedge clk);
    #1 chk(link_sample, {12'hABC, 3'b000, e});
    chk({15'h0000, link_valid}, 16'h0001);
  endtask

  // marker and sample launched on one edge must leave in one link word
  task automatic align();
    int n;
    @(posedge clk);
    conv_sample <= 12'h123;
    marker_pin  <= 1'b1;
    for (n = 0; n < 20 && link_sample[15:4] !== 12'h123; n++) begin
      @(posedge clk);
      #1 if (link_sample[15:4] === 12'hABC) chk(link_sample, 16'hABC0);
    end
    chk({15'h0000, n < 20}, 16'h0001);
    chk(link_sample, 16'h1231);
    @(posedge clk);
    conv_sample <= 12'hABC;
    marker_pin  <= 1'b0;
  endtask

  function automatic logic [15:0] lnk();
    return {12'h000, link_reset_b, serializer_power_up, link_clock_gate_en, multiframe_clock_counter_reset_b};
  endfunction

  task automatic summarize();
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    rst_b       <= 1'b1;
    conv_sample <= 12'hABC;
    conv_valid  <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ofs[i], rstv[i]);
    rd(12'hFFF, 8'h00);
    // every dither setting, reserved bits kept at zero
    for (int v = 0; v < 8; v++) begin
      wr(12'h09D, 8'(v));
      chk({13'h0000, rounding_error_steer, dither_amplitude_select, dither_enable}, 16'(v));
      rd(12'h09D, 8'(v));
    end
    // link off, then a new mode that must wait for the enable
    wr(12'h200, 8'h00);
    @(posedge clk);
    #1 chk(lnk(), 16'h0000);
    wr(12'h201, 8'h2A);
    chk({10'h000, link_mode_active}, 16'h0000);
    chk(link_sample, 16'h0000);
    chk({15'h0000, link_valid}, 16'h0000);
    rd(12'h201, 8'h2A);
    wr(12'h062, 8'h01);
    chk({15'h0000, calibration_enable}, 16'h0001);
    wr(12'h200, 8'h01);
    @(posedge clk);
    #1 chk(lnk(), 16'h000F);
    chk({10'h000, link_mode_active}, 16'h002A);
    @(posedge clk);
    #1 chk({15'h0000, link_init_start}, 16'h0001);
    // mode written while running stays pending
    wr(12'h201, 8'h15);
    chk({10'h000, link_mode_active}, 16'h002A);
    rd(12'h201, 8'h15);
    rd(12'h208, 8'h2A);
    // marker insertion on and off
    wr(12'h161, 8'h01);
    chk({15'h0000, marker_receiver_enable}, 16'h0001);
    wr(12'h160, 8'h01);
    mk(1'b1, 1'b1);
    mk(1'b0, 1'b0);
    align();
    wr(12'h160, 8'h00);
    mk(1'b1, 1'b0);
    chk({12'h000, ila_control_bits}, 16'h0000);
    wr(12'h200, 8'h00);
    wr(12'h062, 8'h00);
    chk({15'h0000, calibration_enable}, 16'h0000);
    // second reset in mid-run
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd(12'h201, 8'h00);
    rd(12'h200, 8'h01);
    summarize();
  end
endmodule // dither_marker_link_ctrl_test

// [inc/dither_marker_pkg.sv]
// types shared by the link control bank
package dither_marker_pkg;

  // link subsystem power sequence
  typedef enum logic [1:0] {
    LINK_OFF,
    LINK_START,
    LINK_RUN
  } link_state_t;

endpackage

// [inc/dither_marker_regs.svh]
// register offsets, field positions, reset values and timing counts of the link control bank
`ifndef DITHER_MARKER_REGS_SVH
`define DITHER_MARKER_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_CONVERTER_DITHER_CTRL 12'h09D
`define OFS_SAMPLE_MARKER_CTRL    12'h160
`define OFS_SERIAL_LINK_ENABLE    12'h200
`define OFS_LINK_OUTPUT_MODE      12'h201
`define OFS_MARKER_RECEIVER_CTRL  12'h161
`define OFS_CALIBRATION_CTRL      12'h062
`define OFS_LINK_STATUS           12'h208

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_DITHER_ENABLE          0
`define BIT_DITHER_AMPLITUDE       1
`define BIT_ROUNDING_ERROR_STEER   2
`define BIT_MARKER_INSERT_ENABLE   0
`define BIT_MARKER_RECEIVER_ENABLE 0
`define BIT_LINK_SUBSYSTEM_ENABLE  0
`define BIT_CALIBRATION_ENABLE     0
`define MSB_LINK_MODE_SELECT       5

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CONVERTER_DITHER_CTRL 8'h00
`define RST_SAMPLE_MARKER_CTRL    8'h00
`define RST_SERIAL_LINK_ENABLE    8'h01
`define RST_LINK_OUTPUT_MODE      8'h00
`define RST_MARKER_RECEIVER_CTRL  8'h00
`define RST_CALIBRATION_CTRL      8'h00

// ****************************************************************
// timing counts
// ****************************************************************
`define MARKER_PIPE_DEPTH 4

`endif
